//--- rtl/msrd_pkg.sv
package msrd_pkg;

	// register byte offsets and reset values
	localparam logic [7:0]  REV_DRIVE_OFS    = 8'h82;
	localparam logic [7:0]  STARTUP_A_OFS    = 8'h84;
	localparam logic [31:0] REV_DRIVE_RST    = 32'h0000_0000;
	localparam logic [31:0] STARTUP_A_RST    = 32'h0000_0000;

	// reverse drive register fields
	localparam int REV_A1_LSB    = 27;
	localparam int REV_A2_LSB    = 23;
	localparam int BRK_ILIM_LSB  = 20;
	localparam int BRK_KP_LSB    = 10;
	localparam int BRK_KI_LSB    = 0;

	// startup register fields
	localparam int METHOD_LSB    = 29;
	localparam int RAMP_LSB      = 25;
	localparam int ALIGN_T_LSB   = 21;
	localparam int ALIGN_I_LSB   = 17;
	localparam int PROBE_LSB     = 14;
	localparam int BRK_EN_BIT    = 1;
	localparam int REV_SEL_BIT   = 0;

	// binary point of the braking gains
	localparam int KP_FRAC_BITS  = 7;
	localparam int KI_FRAC_BITS  = 9;

	// special codes
	localparam logic [2:0] BRK_ILIM_RSVD  = 3'h7;
	localparam logic [3:0] ALIGN_I_RSVD   = 4'he;
	localparam logic [3:0] RAMP_UNLIMITED = 4'hf;

	// rates in 0.01 Hz/s (first order) or 0.01 Hz/s2 (second order)
	localparam logic [31:0] ACCEL_A1_TBL [16] = '{
		32'h1, 32'h5, 32'h64, 32'hfa, 32'h1f4, 32'h3e8, 32'h9c4, 32'h1388,
		32'h1d4c, 32'h2710, 32'h61a8, 32'hc350, 32'h124f8, 32'h186a0,
		32'h7a120, 32'hf4240};
	localparam logic [31:0] ACCEL_A2_TBL [16] = '{
		32'h0, 32'h5, 32'h64, 32'hfa, 32'h1f4, 32'h3e8, 32'h9c4, 32'h1388,
		32'h1d4c, 32'h2710, 32'h61a8, 32'hc350, 32'h124f8, 32'h186a0,
		32'h7a120, 32'hf4240};
	// currents in 1/256 A
	localparam logic [15:0] BRK_ILIM_TBL [8] = '{
		16'h50, 16'ha0, 16'h140, 16'h1e0, 16'h280, 16'h320, 16'h3c0, 16'h0};
	localparam logic [15:0] ALIGN_I_TBL [16] = '{
		16'h14, 16'h28, 16'h50, 16'ha0, 16'hf0, 16'h140, 16'h190, 16'h1e0,
		16'h230, 16'h280, 16'h2d0, 16'h320, 16'h370, 16'h3c0, 16'h0, 16'h0};
	// ramp in 0.1 A/s, top code unlimited
	localparam logic [15:0] RAMP_TBL [16] = '{
		16'h1, 16'ha, 16'h32, 16'h64, 16'h96, 16'hfa, 16'h1f4, 16'h3e8,
		16'h5dc, 16'h7d0, 16'h9c4, 16'h1388, 16'h2710, 16'h4e20,
		16'hc350, 16'hffff};
	// align time in ms
	localparam logic [15:0] ALIGN_T_TBL [16] = '{
		16'ha, 16'h32, 16'h64, 16'hc8, 16'h12c, 16'h190, 16'h1f4, 16'h2ee,
		16'h3e8, 16'h5dc, 16'h7d0, 16'hbb8, 16'hfa0, 16'h1388, 16'h1d4c,
		16'h2710};
	// probe pulse rate in Hz
	localparam logic [15:0] PROBE_TBL [8] = '{
		16'h32, 16'h64, 16'hfa, 16'h1f4, 16'h3e8, 16'h7d0, 16'h1388,
		16'h2710};

	typedef enum logic [3:0] {
		START_SINGLE_ALIGN = 4'b0001,
		START_DOUBLE_ALIGN = 4'b0010,
		START_ROTOR_PROBE  = 4'b0100,
		START_SLOW_CYCLE   = 4'b1000
	} msrd_method_e;

	typedef struct packed {
		logic [31:0] reverse_accel_first_order;
		logic [31:0] reverse_accel_second_order;
		logic [15:0] brake_bus_ilim;
		logic        brake_ilim_rsvd;
		logic [9:0]  regen_brake_prop_gain;
		logic [9:0]  regen_brake_integral_gain;
	} msrd_rev_s;

	typedef struct packed {
		msrd_method_e startup_method_select;
		logic [15:0]  ramp_rate;
		logic         ramp_unlimited;
		logic [15:0]  align_time_ms;
		logic [15:0]  alignment_current_cap;
		logic         align_ilim_rsvd;
		logic [15:0]  rotor_position_probe_rate;
		logic         regen_brake_en;
		logic         reverse_coeff_source_select;
	} msrd_start_s;

	typedef struct packed {
		logic [31:0] accel_first;
		logic [31:0] accel_second;
		logic [15:0] ol_current;
	} msrd_ol_s;

endpackage : msrd_pkg

//--- rtl/msrd_regs.sv
// How it works
// - first-order reverse acceleration code maps to sixteen rates via table
// - second-order reverse acceleration code maps to rates, zero meaning none
// - braking bus current limit from three-bit code, code seven reserved
// - braking proportional gain is raw ten bits with seven fraction bits
// - braking integral gain is raw ten bits with nine fraction bits
// - startup method decoded from two bits into one-hot method
// - one ramp rate for align, slow cycle, open loop; top unlimited
// - align duration decoded from four bits, ten ms to ten seconds
// - align or slow cycle current cap, codes fourteen, fifteen reserved
// - probe pulse rate decoded from three bits, fifty Hz to ten kHz
// - startup register sits at 0x84 and resets to zero
// - active braking enabled only while startup bit one is set
// - startup bit zero picks reverse or forward open-loop coefficients
// - reverse drive register sits at 0x82 and resets to zero
module msrd_regs
	import msrd_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// register access
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [31:0] REG_WDATA,
	output logic      [31:0] REG_RDATA,
	output logic             REG_RVALID,
	output logic             REG_HIT,
	// forward and reverse open-loop values from elsewhere
	input  wire msrd_ol_s    FWD_OL,
	input  wire msrd_ol_s    REV_OL,
	// decoded settings
	output msrd_rev_s        REV_CFG,
	output msrd_start_s      START_CFG,
	output msrd_ol_s         OL_CFG
);

	logic [31:0] rev_r;
	logic [31:0] start_r;
	logic [31:0] rdata_r;
	logic        rvalid_r;
	logic        hit;
	msrd_rev_s   rev_cfg_r;
	msrd_start_s start_cfg_r;
	msrd_ol_s    ol_cfg_r;

	logic [3:0] a1_code;
	logic [3:0] a2_code;
	logic [2:0] bilim_code;
	logic [1:0] method_code;
	logic [3:0] ramp_code;
	logic [3:0] at_code;
	logic [3:0] ai_code;
	logic [2:0] probe_code;

	assign a1_code     = rev_r[REV_A1_LSB +: 4];
	assign a2_code     = rev_r[REV_A2_LSB +: 4];
	assign bilim_code  = rev_r[BRK_ILIM_LSB +: 3];
	assign method_code = start_r[METHOD_LSB +: 2];
	assign ramp_code   = start_r[RAMP_LSB +: 4];
	assign at_code     = start_r[ALIGN_T_LSB +: 4];
	assign ai_code     = start_r[ALIGN_I_LSB +: 4];
	assign probe_code  = start_r[PROBE_LSB +: 3];

	always_comb begin
		hit = 1'b0;
		if (REG_ADDR == REV_DRIVE_OFS) begin
			hit = 1'b1;
		end else if (REG_ADDR == STARTUP_A_OFS) begin
			hit = 1'b1;
		end
	end

	// reverse drive register storage
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rev_r <= REV_DRIVE_RST;
		end else if (REG_WR && REG_ADDR == REV_DRIVE_OFS) begin
			rev_r <= REG_WDATA;
		end
	end

	// startup register storage
	always_ff @(posedge CLK) begin
		if (SRST) begin
			start_r <= STARTUP_A_RST;
		end else if (REG_WR && REG_ADDR == STARTUP_A_OFS) begin
			start_r <= REG_WDATA;
		end
	end

	// read port, one cycle latency, unmapped reads zero
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdata_r  <= 32'h0;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= REG_RD;
			if (!REG_RD) begin
				rdata_r <= 32'h0;
			end else if (REG_ADDR == REV_DRIVE_OFS) begin
				rdata_r <= rev_r;
			end else if (REG_ADDR == STARTUP_A_OFS) begin
				rdata_r <= start_r;
			end else begin
				rdata_r <= 32'h0;
			end
		end
	end

	// reverse drive decode
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rev_cfg_r <= '0;
		end else begin
			rev_cfg_r.reverse_accel_first_order  <= ACCEL_A1_TBL[a1_code];
			rev_cfg_r.reverse_accel_second_order <= ACCEL_A2_TBL[a2_code];
			rev_cfg_r.brake_bus_ilim   <= BRK_ILIM_TBL[bilim_code];
			rev_cfg_r.brake_ilim_rsvd  <= (bilim_code == BRK_ILIM_RSVD);
			rev_cfg_r.regen_brake_prop_gain <= rev_r[BRK_KP_LSB +: 10];
			rev_cfg_r.regen_brake_integral_gain <=
				rev_r[BRK_KI_LSB +: 10];
		end
	end

	// startup decode
	always_ff @(posedge CLK) begin
		if (SRST) begin
			start_cfg_r <= '0;
			start_cfg_r.startup_method_select <= START_SINGLE_ALIGN;
		end else begin
			case (method_code)
				2'h0: start_cfg_r.startup_method_select <=
					START_SINGLE_ALIGN;
				2'h1: start_cfg_r.startup_method_select <=
					START_DOUBLE_ALIGN;
				2'h2: start_cfg_r.startup_method_select <=
					START_ROTOR_PROBE;
				default: start_cfg_r.startup_method_select <=
					START_SLOW_CYCLE;
			endcase
			start_cfg_r.ramp_rate      <= RAMP_TBL[ramp_code];
			start_cfg_r.ramp_unlimited <= (ramp_code == RAMP_UNLIMITED);
			start_cfg_r.align_time_ms  <= ALIGN_T_TBL[at_code];
			start_cfg_r.alignment_current_cap <= ALIGN_I_TBL[ai_code];
			start_cfg_r.align_ilim_rsvd <= (ai_code >= ALIGN_I_RSVD);
			start_cfg_r.rotor_position_probe_rate <=
				PROBE_TBL[probe_code];
			start_cfg_r.regen_brake_en <= start_r[BRK_EN_BIT];
			start_cfg_r.reverse_coeff_source_select <=
				start_r[REV_SEL_BIT];
		end
	end

	// open-loop coefficient source
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ol_cfg_r <= '0;
		end else if (start_r[REV_SEL_BIT]) begin
			ol_cfg_r.accel_first  <= ACCEL_A1_TBL[a1_code];
			ol_cfg_r.accel_second <= ACCEL_A2_TBL[a2_code];
			ol_cfg_r.ol_current   <= REV_OL.ol_current;
		end else begin
			ol_cfg_r <= FWD_OL;
		end
	end

	assign REG_RDATA  = rdata_r;
	assign REG_RVALID = rvalid_r;
	assign REG_HIT    = hit;
	assign REV_CFG    = rev_cfg_r;
	assign START_CFG  = start_cfg_r;
	assign OL_CFG     = ol_cfg_r;

endmodule : msrd_regs

//--- verification/msrd_regs_asserts.sv
module msrd_regs_asserts
	import msrd_pkg::*;
(
	// clock and reset
	input wire logic        CLK,
	input wire logic        SRST,
	// register access
	input wire logic [7:0]  REG_ADDR,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	input wire logic        REG_RVALID,
	input wire logic        REG_HIT,
	// open-loop and decoded settings
	input wire msrd_ol_s    FWD_OL,
	input wire msrd_ol_s    REV_OL,
	input wire msrd_rev_s   REV_CFG,
	input wire msrd_start_s START_CFG,
	input wire msrd_ol_s    OL_CFG
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	sequence s_wr_st; REG_WR && REG_ADDR == STARTUP_A_OFS; endsequence
	sequence s_wr_rv; REG_WR && REG_ADDR == REV_DRIVE_OFS; endsequence
	property p_rvalid; REG_RD |=> REG_RVALID; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read unanswered");
	property p_idle; !REG_RD |=> !REG_RVALID && REG_RDATA == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("spurious read data");
	property p_hit;
		REG_HIT == (REG_ADDR == REV_DRIVE_OFS || REG_ADDR == STARTUP_A_OFS);
	endproperty
	a_hit: assert property (p_hit) else $error("bad hit");
	property p_brk;
		s_wr_st |-> ##2
			START_CFG.regen_brake_en == $past(REG_WDATA[1], 2);
	endproperty
	a_brk: assert property (p_brk) else $error("brake enable wrong");
	property p_sel;
		s_wr_st |-> ##2 START_CFG.reverse_coeff_source_select ==
			$past(REG_WDATA[0], 2);
	endproperty
	a_sel: assert property (p_sel) else $error("source select wrong");
	property p_meth;
		s_wr_st |-> ##2 START_CFG.startup_method_select ==
			4'h1 << $past(REG_WDATA[30:29], 2);
	endproperty
	a_meth: assert property (p_meth) else $error("method wrong");
	property p_kp;
		s_wr_rv |-> ##2 REV_CFG.regen_brake_prop_gain ==
			$past(REG_WDATA[19:10], 2);
	endproperty
	a_kp: assert property (p_kp) else $error("kp wrong");
	property p_ki;
		s_wr_rv |-> ##2 REV_CFG.regen_brake_integral_gain ==
			$past(REG_WDATA[9:0], 2);
	endproperty
	a_ki: assert property (p_ki) else $error("ki wrong");
	property p_fwd;
		!$past(SRST) && !START_CFG.reverse_coeff_source_select |->
			OL_CFG == $past(FWD_OL);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward values not used");
	c_rd: cover property (REG_RVALID && REG_RDATA != 32'h0);
	c_wr: cover property (s_wr_st ##1 s_wr_rv);
	c_rev: cover property (START_CFG.reverse_coeff_source_select);
endmodule : msrd_regs_asserts

bind msrd_regs msrd_regs_asserts u_msrd_regs_asserts (.CLK(CLK), .SRST(SRST),
	.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_HIT(REG_HIT),
	.FWD_OL(FWD_OL), .REV_OL(REV_OL), .REV_CFG(REV_CFG), .START_CFG(START_CFG),
	.OL_CFG(OL_CFG));

//--- verification/msrd_regs_tb_top.sv
module msrd_regs_tb_top
	import msrd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK = 0, SRST = 1, REG_WR = 0, REG_RD = 0, REG_HIT, REG_RVALID;
	logic [7:0]  REG_ADDR = 8'h0;
	logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d, e, s;
	msrd_ol_s    FWD_OL = '0, REV_OL = '0, OL_CFG;
	msrd_rev_s   REV_CFG;
	msrd_start_s START_CFG;
	logic [31:0] expq [$];
	integer      seed = 32'h71dfd7f2;
	int          fails = 0, n_compared = 0;
	always #2 CLK = ~CLK;
	msrd_regs u_msrd_regs (.CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_HIT(REG_HIT),
		.FWD_OL(FWD_OL), .REV_OL(REV_OL), .REV_CFG(REV_CFG),
		.START_CFG(START_CFG), .OL_CFG(OL_CFG));
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(negedge CLK);
		REG_ADDR = a;
		REG_WDATA = v;
		REG_WR = 1;
		@(negedge CLK);
		REG_WR = 0;
	endtask : wr
	// expected read data queued; monitor pops it when valid shows
	task automatic rd(input logic [7:0] a, input logic [31:0] v);
		@(negedge CLK);
		REG_ADDR = a;
		REG_RD = 1;
		expq.push_back(v);
		#1 chk(REG_HIT, a == 8'h82 || a == 8'h84);
		@(negedge CLK);
		REG_RD = 0;
	endtask : rd
	always @(posedge CLK) begin
		if (REG_RVALID === 1'b1) begin
			chk(REG_RDATA, expq.size() > 0 ? expq.pop_front() : 'x);
		end
	end
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	initial begin
		#20000;
		fails++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge CLK);
		@(negedge CLK);
		SRST = 0;
		rd(8'h84, 32'h0);
		rd(8'h82, 32'h0);
		rd(8'h86, 32'h0);
		// reserved current codes and bit 31 kept clear by software
		for (int i = 0; i < 16; i++) begin
			s = $random(seed);
			d = {1'b0, i[3:0], i[3:0], 3'(i % 7), s[19:0]};
			e = {1'b0, i[1:0], i[3:0], i[3:0], 4'(i % 14), i[2:0],
				s[13:0]};
			FWD_OL = 80'({$random(seed), $random(seed), $random(seed)});
			REV_OL = 80'({$random(seed), $random(seed), $random(seed)});
			wr(8'h82, d);
			wr(8'h84, e);
			@(negedge CLK);
			chk(REV_CFG.reverse_accel_first_order, ACCEL_A1_TBL[i]);
			chk(REV_CFG.reverse_accel_second_order, ACCEL_A2_TBL[i]);
			chk({REV_CFG.brake_ilim_rsvd, REV_CFG.brake_bus_ilim},
				{1'b0, BRK_ILIM_TBL[i % 7]});
			chk(REV_CFG.regen_brake_prop_gain, d[19:10]);
			chk(REV_CFG.regen_brake_integral_gain, d[9:0]);
			chk(START_CFG.startup_method_select, 4'h1 << i[1:0]);
			chk({START_CFG.ramp_unlimited, START_CFG.ramp_rate},
				{i == 15, RAMP_TBL[i]});
			chk(START_CFG.align_time_ms, ALIGN_T_TBL[i]);
			chk({START_CFG.align_ilim_rsvd, START_CFG.alignment_current_cap},
				{1'b0, ALIGN_I_TBL[i % 14]});
			chk(START_CFG.rotor_position_probe_rate, PROBE_TBL[i[2:0]]);
			chk(START_CFG.regen_brake_en, e[1]);
			chk(OL_CFG, e[0] ? {ACCEL_A1_TBL[i], ACCEL_A2_TBL[i],
				REV_OL.ol_current} : FWD_OL);
			wr({4'h9, i[3:0]}, ~s);
			rd(8'h82, d);
			rd(8'h84, e);
		end
		@(negedge CLK);
		SRST = 1;
		@(negedge CLK);
		SRST = 0;
		rd(8'h84, 32'h0);
		rd(8'h82, 32'h0);
		chk(START_CFG.align_time_ms, ALIGN_T_TBL[0]);
		chk(REV_CFG.reverse_accel_first_order, ACCEL_A1_TBL[0]);
		repeat (2) @(negedge CLK);
		chk(expq.size(), 0);
		close_out();
	end
endmodule : msrd_regs_tb_top
